// ===== core/bpc_pkg.sv
// Constants, types and helpers of the branch and processor control block.
// Assumes a 100 MHz APB clock and a word-wide memory port outside.
// Operation
// RULE1 - Far direct branch loads pointer and segment
// RULE2 - Far indirect: low word pointer, high segment
// RULE3 - Conditional branch adds signed byte displacement
// RULE4 - Unsigned conditions from carry and zero
// RULE5 - Signed conditions from sign, overflow, zero
// RULE6 - Single flag branches, set and clear forms
// RULE7 - Loop decrements count, branches when nonzero
// RULE8 - Loop while zero needs count and zero
// RULE9 - Loop while nonzero needs count, zero clear
// RULE10 - Count zero branch leaves count untouched
// RULE11 - Acknowledge cycle only for maskable requests
// RULE12 - Trap entry pushes flags, segment, pointer
// RULE13 - One byte breakpoint form implies type three
// RULE14 - Overflow trap uses vector 10H if set
// RULE15 - Trap return pops pointer, segment, flags
// RULE16 - Flag operations touch only their flag
// RULE17 - Interrupt enable clear masks maskable line
// RULE18 - Enable takes effect after next instruction
// RULE19 - Halt ends on reset or interrupt
// RULE20 - Wait stalls while test input inactive
// RULE21 - Escape memory operand read and discarded
// RULE22 - Lock prefix asserts lock for next instruction
// RULE23 - Taken transfer flushes queue, fetches target
// RULE24 - Conditions use committed flags and count
package bpc_pkg;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_OPND = 8'h04;
  localparam logic [7:0] OFS_IP = 8'h08;
  localparam logic [7:0] OFS_CS = 8'h0c;
  localparam logic [7:0] OFS_SP = 8'h10;
  localparam logic [7:0] OFS_CX = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_EA = 8'h20;
  localparam logic [7:0] OFS_SS = 8'h24;
  localparam logic [7:0] OFS_FETCH = 8'h28;
  localparam logic [7:0] OFS_CFG = 8'h2c;
  localparam int CMD_COND_LSB = 8;
  localparam int CMD_ESC_MEM_BIT = 12;
  localparam int CMD_ESC_OP_LSB = 16;
  localparam int FL_CARRY = 0;
  localparam int FL_PARITY = 2;
  localparam int FL_ZERO = 6;
  localparam int FL_SIGN = 7;
  localparam int FL_TRAP = 8;
  localparam int FL_IRQ_EN = 9;
  localparam int FL_DIR = 10;
  localparam int FL_OVERFLOW = 11;
  localparam logic [15:0] FLAGS_RST = 16'h0002;
  localparam logic [15:0] IP_RST = 16'h0000;
  localparam logic [15:0] CS_RST = 16'hffff;
  localparam logic [7:0] VEC_NMI = 8'h02;
  localparam logic [7:0] VEC_BREAK = 8'h03;
  localparam logic [7:0] VEC_OVF = 8'h04;
  typedef enum logic [4:0] {
    OP_IDLE = 5'h00, OP_JMP_FAR = 5'h01, OP_JMP_FAR_IND = 5'h02,
    OP_JCC = 5'h03, OP_LOOP = 5'h04, OP_LOOPZ = 5'h05,
    OP_LOOPNZ = 5'h06, OP_BRANCH_IF_COUNT_ZERO = 5'h07, OP_INT = 5'h08,
    OP_INT3 = 5'h09, OP_INTO = 5'h0a, OP_TRAP_RETURN = 5'h0b,
    OP_CLC = 5'h0c, OP_STC = 5'h0d, OP_CMC = 5'h0e, OP_CLD = 5'h0f,
    OP_STD = 5'h10, OP_CLI = 5'h11, OP_STI = 5'h12, OP_HLT = 5'h13,
    OP_WAIT = 5'h14, OP_ESC = 5'h15, OP_LOCK = 5'h16
  } bpc_op_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_INTA = 4'h1, S_PUSH_F = 4'h2, S_PUSH_CS = 4'h3,
    S_PUSH_IP = 4'h4, S_VEC_OFF = 4'h5, S_VEC_SEG = 4'h6,
    S_POP_IP = 4'h7, S_POP_CS = 4'h8, S_POP_F = 4'h9, S_IND_LO = 4'ha,
    S_IND_HI = 4'hb, S_ESC_RD = 4'hc, S_HALT = 4'hd, S_WAIT = 4'he,
    S_FETCH = 4'hf
  } bpc_state_t;
  function automatic logic [19:0] bpc_phys(input logic [15:0] seg,
                                           input logic [15:0] off);
    bpc_phys = {seg, 4'h0} + {4'h0, off};
  endfunction
  function automatic logic bpc_cond(input logic [3:0] cc,
                                    input logic [15:0] f);
    logic c, z, s, o, p, base;
    c = f[FL_CARRY];
    z = f[FL_ZERO];
    s = f[FL_SIGN];
    o = f[FL_OVERFLOW];
    p = f[FL_PARITY];
    case (cc[3:1])
      3'h0: base = o;
      3'h1: base = c;
      3'h2: base = z;
      3'h3: base = c | z;
      3'h4: base = s;
      3'h5: base = p;
      3'h6: base = s ^ o;
      default: base = (s ^ o) | z;
    endcase
    bpc_cond = base ^ cc[0];
  endfunction
endpackage

// ===== core/bpc_core.sv
// Program transfer and processor control execution unit.
// Assumes an APB master, a word memory port and pin level interrupts.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module bpc_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_we,
  output logic mem_fetch,
  output logic [19:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic nmi_n,
  input wire logic maskable_request_line,
  input wire logic test_n,
  output logic inta_req,
  input wire logic inta_ack,
  input wire logic [7:0] inta_type,
  output logic lock_out,
  output logic queue_flush,
  output logic [5:0] esc_opcode
);
  import bpc_pkg::*;

  logic [15:0] instruction_pointer, code_seg, stack_pointer;
  logic [15:0] stack_seg, count_register, flags_r, fetch_word_r;
  logic [31:0] cmd_r, opnd_r, cmd_w;
  logic [19:0] ea_r;
  logic max_mode_r, lock_pend_r, lock_act_r, sti_shadow_r, nmi_pend_r;
  logic flush_r;
  logic [7:0] vtype_r;
  logic [5:0] esc_op_r;
  bpc_state_t state_r, state_nxt;
  logic [2:0] nmi_s, irq_s, test_s;
  logic nmi_lvl_r, irq_lvl_r, test_lvl_r, nmi_lvl_d;

  logic apb_wr, apb_rd_setup, go, done, nmi_edge, irq_ok, ack;
  logic [3:0] cc;
  bpc_op_t op;
  logic [15:0] cx_dec, ip_rel, sp_dn, sp_up;

  assign apb_wr = psel & penable & pwrite;
  assign apb_rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  // A launch decodes the word being written, not the stored one.
  assign cmd_w = go ? pwdata : cmd_r;
  assign op = bpc_op_t'(cmd_w[4:0]);
  assign cc = cmd_w[CMD_COND_LSB +: 4];
  assign go = apb_wr & (paddr == OFS_CMD) & (state_r == S_IDLE) &
              ~nmi_pend_r & ~irq_ok;
  assign cx_dec = count_register - 16'h0001;
  assign ip_rel = instruction_pointer + {{8{opnd_r[7]}}, opnd_r[7:0]};
  assign sp_dn = stack_pointer - 16'h0002;
  assign sp_up = stack_pointer + 16'h0002;
  assign ack = mem_req & mem_ack;
  assign nmi_edge = nmi_lvl_d & ~nmi_lvl_r;
  // Maskable line is ignored while disabled or in the enable shadow.
  assign irq_ok = irq_lvl_r & flags_r[FL_IRQ_EN] & ~sti_shadow_r; // [RULE17] [RULE18]
  assign lock_out = lock_act_r & max_mode_r; // [RULE22]
  assign queue_flush = flush_r;
  assign esc_opcode = esc_op_r;

  // Pin inputs: three stages, a change counts when stages two and three agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_s <= 3'h7;
      irq_s <= 3'h0;
      test_s <= 3'h7;
      nmi_lvl_r <= 1'b1;
      nmi_lvl_d <= 1'b1;
      irq_lvl_r <= 1'b0;
      test_lvl_r <= 1'b1;
    end else begin
      nmi_s <= {nmi_s[1:0], nmi_n};
      irq_s <= {irq_s[1:0], maskable_request_line};
      test_s <= {test_s[1:0], test_n};
      if (nmi_s[1] == nmi_s[2]) nmi_lvl_r <= nmi_s[2];
      if (irq_s[1] == irq_s[2]) irq_lvl_r <= irq_s[2];
      if (test_s[1] == test_s[2]) test_lvl_r <= test_s[2];
      nmi_lvl_d <= nmi_lvl_r;
    end
  end

  // Memory port requests, driven from the sequencer state.
  always_comb begin
    mem_req = 1'b1;
    mem_we = 1'b0;
    mem_fetch = 1'b0;
    mem_addr = 20'h00000;
    mem_wdata = 16'h0000;
    case (state_r)
      S_PUSH_F: begin
        mem_we = 1'b1;
        mem_addr = bpc_phys(stack_seg, sp_dn);
        mem_wdata = flags_r;
      end
      S_PUSH_CS: begin
        mem_we = 1'b1;
        mem_addr = bpc_phys(stack_seg, sp_dn);
        mem_wdata = code_seg;
      end
      S_PUSH_IP: begin
        mem_we = 1'b1;
        mem_addr = bpc_phys(stack_seg, sp_dn);
        mem_wdata = instruction_pointer;
      end
      S_VEC_OFF: mem_addr = {10'h000, vtype_r, 2'b00}; // [RULE12]
      S_VEC_SEG: mem_addr = {10'h000, vtype_r, 2'b00} + 20'h00002;
      S_POP_IP, S_POP_CS, S_POP_F:
        mem_addr = bpc_phys(stack_seg, stack_pointer);
      S_IND_LO, S_ESC_RD: mem_addr = ea_r; // [RULE21]
      S_IND_HI: mem_addr = ea_r + 20'h00002;
      S_FETCH: begin
        mem_fetch = 1'b1;
        mem_addr = bpc_phys(code_seg, instruction_pointer); // [RULE23]
      end
      default: mem_req = 1'b0;
    endcase
  end

  assign inta_req = (state_r == S_INTA); // [RULE11]

  // Sequencer next state.
  always_comb begin
    state_nxt = state_r;
    done = 1'b0;
    case (state_r)
      S_IDLE, S_HALT: begin
        if (nmi_pend_r) state_nxt = S_PUSH_F;
        else if (irq_ok) state_nxt = S_INTA; // [RULE19]
        else if (go) begin
          done = 1'b1;
          case (op)
            OP_JMP_FAR: state_nxt = S_FETCH;
            OP_JMP_FAR_IND: state_nxt = S_IND_LO;
            OP_JCC: if (bpc_cond(cc, flags_r)) state_nxt = S_FETCH; // [RULE24]
            OP_LOOP: if (cx_dec != 16'h0000) state_nxt = S_FETCH;
            OP_LOOPZ:
              if (cx_dec != 16'h0000 && flags_r[FL_ZERO])
                state_nxt = S_FETCH;
            OP_LOOPNZ:
              if (cx_dec != 16'h0000 && !flags_r[FL_ZERO])
                state_nxt = S_FETCH;
            OP_BRANCH_IF_COUNT_ZERO: if (count_register == 16'h0000) state_nxt = S_FETCH;
            OP_INT, OP_INT3: state_nxt = S_PUSH_F;
            OP_INTO: if (flags_r[FL_OVERFLOW]) state_nxt = S_PUSH_F; // [RULE14]
            OP_TRAP_RETURN: state_nxt = S_POP_IP;
            OP_HLT: state_nxt = S_HALT;
            OP_WAIT: state_nxt = S_WAIT;
            OP_ESC: if (cmd_w[CMD_ESC_MEM_BIT]) state_nxt = S_ESC_RD;
            default: state_nxt = S_IDLE;
          endcase
          if (state_nxt != S_IDLE) done = 1'b0;
        end
      end
      S_INTA: if (inta_ack) state_nxt = S_PUSH_F;
      S_PUSH_F: if (ack) state_nxt = S_PUSH_CS;
      S_PUSH_CS: if (ack) state_nxt = S_PUSH_IP;
      S_PUSH_IP: if (ack) state_nxt = S_VEC_OFF;
      S_VEC_OFF: if (ack) state_nxt = S_VEC_SEG;
      S_VEC_SEG: if (ack) state_nxt = S_FETCH;
      S_POP_IP: if (ack) state_nxt = S_POP_CS;
      S_POP_CS: if (ack) state_nxt = S_POP_F;
      S_POP_F: if (ack) state_nxt = S_FETCH;
      S_IND_LO: if (ack) state_nxt = S_IND_HI;
      S_IND_HI: if (ack) state_nxt = S_FETCH;
      S_ESC_RD, S_FETCH: if (ack) state_nxt = S_IDLE;
      S_WAIT: if (!test_lvl_r) state_nxt = S_IDLE; // [RULE20]
      default: state_nxt = S_IDLE;
    endcase
    if ((state_r != S_IDLE) && (state_r != S_HALT) &&
        (state_nxt == S_IDLE)) done = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_r <= S_IDLE;
    else state_r <= state_nxt;
  end

  // Pending nonmaskable edge; a new edge wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) nmi_pend_r <= 1'b0;
    else if (nmi_edge) nmi_pend_r <= 1'b1;
    else if ((state_r == S_IDLE || state_r == S_HALT) &&
             state_nxt == S_PUSH_F && !go) nmi_pend_r <= 1'b0;
  end

  // Interrupt type latch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) vtype_r <= 8'h00;
    else if ((state_r == S_IDLE || state_r == S_HALT) && nmi_pend_r)
      vtype_r <= VEC_NMI;
    else if (state_r == S_INTA && inta_ack) vtype_r <= inta_type;
    else if (go) begin
      case (op)
        OP_INT3: vtype_r <= VEC_BREAK; // [RULE13]
        OP_INTO: vtype_r <= VEC_OVF; // [RULE14]
        default: vtype_r <= opnd_r[7:0];
      endcase
    end
  end

  // Lock prefix, enable shadow and escape opcode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_pend_r <= 1'b0;
      lock_act_r <= 1'b0;
      sti_shadow_r <= 1'b0;
      esc_op_r <= 6'h00;
      flush_r <= 1'b0;
    end else begin
      flush_r <= (state_r == S_FETCH) & ack;
      if (go) begin
        lock_pend_r <= (op == OP_LOCK);
        lock_act_r <= lock_pend_r & (op != OP_LOCK); // [RULE22]
        sti_shadow_r <= (op == OP_STI); // [RULE18]
        if (op == OP_ESC) esc_op_r <= cmd_w[CMD_ESC_OP_LSB +: 6];
      end else if (state_r == S_IDLE) begin
        lock_act_r <= 1'b0;
      end
    end
  end

  // Architectural registers: sequencer updates, otherwise APB writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instruction_pointer <= IP_RST;
      code_seg <= CS_RST;
      stack_pointer <= 16'h0000;
      stack_seg <= 16'h0000;
      count_register <= 16'h0000;
      flags_r <= FLAGS_RST;
      fetch_word_r <= 16'h0000;
    end else if (go) begin
      case (op)
        OP_JMP_FAR: begin
          instruction_pointer <= opnd_r[15:0]; // [RULE1]
          code_seg <= opnd_r[31:16];
        end
        OP_JCC:
          if (bpc_cond(cc, flags_r)) instruction_pointer <= ip_rel; // [RULE3] [RULE4] [RULE5] [RULE6]
        OP_LOOP: begin
          count_register <= cx_dec; // [RULE7]
          if (cx_dec != 16'h0000) instruction_pointer <= ip_rel;
        end
        OP_LOOPZ: begin
          count_register <= cx_dec; // [RULE8]
          if (cx_dec != 16'h0000 && flags_r[FL_ZERO])
            instruction_pointer <= ip_rel;
        end
        OP_LOOPNZ: begin
          count_register <= cx_dec; // [RULE9]
          if (cx_dec != 16'h0000 && !flags_r[FL_ZERO])
            instruction_pointer <= ip_rel;
        end
        OP_BRANCH_IF_COUNT_ZERO:
          if (count_register == 16'h0000) instruction_pointer <= ip_rel; // [RULE10]
        OP_CLC: flags_r[FL_CARRY] <= 1'b0; // [RULE16]
        OP_STC: flags_r[FL_CARRY] <= 1'b1;
        OP_CMC: flags_r[FL_CARRY] <= ~flags_r[FL_CARRY];
        OP_CLD: flags_r[FL_DIR] <= 1'b0;
        OP_STD: flags_r[FL_DIR] <= 1'b1;
        OP_CLI: flags_r[FL_IRQ_EN] <= 1'b0;
        OP_STI: flags_r[FL_IRQ_EN] <= 1'b1;
        default: flags_r <= flags_r;
      endcase
    end else if (ack) begin
      case (state_r)
        S_PUSH_F: begin
          stack_pointer <= sp_dn; // [RULE12]
          flags_r[FL_TRAP] <= 1'b0;
          flags_r[FL_IRQ_EN] <= 1'b0;
        end
        S_PUSH_CS, S_PUSH_IP: stack_pointer <= sp_dn;
        S_VEC_OFF, S_IND_LO: instruction_pointer <= mem_rdata; // [RULE2]
        S_VEC_SEG, S_IND_HI: code_seg <= mem_rdata;
        S_POP_IP: begin
          instruction_pointer <= mem_rdata; // [RULE15]
          stack_pointer <= sp_up;
        end
        S_POP_CS: begin
          code_seg <= mem_rdata;
          stack_pointer <= sp_up;
        end
        S_POP_F: begin
          flags_r <= mem_rdata;
          stack_pointer <= sp_up;
        end
        S_FETCH: fetch_word_r <= mem_rdata; // [RULE23]
        default: fetch_word_r <= fetch_word_r;
      endcase
    end else if (apb_wr && state_r == S_IDLE) begin
      case (paddr)
        OFS_IP: instruction_pointer <= pwdata[15:0];
        OFS_CS: code_seg <= pwdata[15:0];
        OFS_SP: stack_pointer <= pwdata[15:0];
        OFS_SS: stack_seg <= pwdata[15:0];
        OFS_CX: count_register <= pwdata[15:0];
        OFS_FLAGS: flags_r <= pwdata[15:0];
        default: fetch_word_r <= fetch_word_r;
      endcase
    end
  end

  // Command, operand, address and configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= 32'h00000000;
      opnd_r <= 32'h00000000;
      ea_r <= 20'h00000;
      max_mode_r <= 1'b0;
    end else if (apb_wr && state_r == S_IDLE) begin
      case (paddr)
        OFS_CMD: cmd_r <= pwdata;
        OFS_OPND: opnd_r <= pwdata;
        OFS_EA: ea_r <= pwdata[19:0];
        OFS_CFG: max_mode_r <= pwdata[0];
        default: cmd_r <= cmd_r;
      endcase
    end
  end

  // Read data is captured in the setup phase so it stands in the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      case (paddr)
        OFS_CMD: prdata <= cmd_r;
        OFS_OPND: prdata <= opnd_r;
        OFS_IP: prdata[15:0] <= instruction_pointer;
        OFS_CS: prdata[15:0] <= code_seg;
        OFS_SP: prdata[15:0] <= stack_pointer;
        OFS_CX: prdata[15:0] <= count_register;
        OFS_FLAGS: prdata[15:0] <= flags_r;
        OFS_STATUS: prdata[9:0] <= {lock_pend_r, sti_shadow_r,
          nmi_pend_r, lock_out, state_r != S_IDLE,
          state_r == S_WAIT, state_r == S_HALT, 3'h0};
        OFS_EA: prdata[19:0] <= ea_r;
        OFS_SS: prdata[15:0] <= stack_seg;
        OFS_FETCH: prdata[15:0] <= fetch_word_r;
        OFS_CFG: prdata[0] <= max_mode_r;
        default: pslverr <= 1'b1;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== sim/bpc_core_properties.sv
// Concurrent checks on the ports of the branch and processor control core.
// Assumes the bind at the foot attaches it to every bpc_core instance.
`timescale 1ns/10ps
`default_nettype none
module bpc_core_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_fetch,
  input wire logic [19:0] mem_addr,
  input wire logic mem_ack,
  input wire logic maskable_request_line,
  input wire logic inta_req,
  input wire logic inta_ack,
  input wire logic queue_flush
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_apb_zero_wait: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_unmapped_error: assert property (
    psel && !penable && paddr > 8'h2c |=> pslverr)
    else $error("unmapped access without error");
  a_flush_after_fetch: assert property (
    mem_req && mem_ack && mem_fetch |=> queue_flush)
    else $error("target fetch not followed by flush");
  a_flush_has_cause: assert property (
    queue_flush |-> $past(mem_req && mem_ack && mem_fetch))
    else $error("flush without a target fetch");
  a_flush_one_pulse: assert property (queue_flush |=> !queue_flush)
    else $error("flush longer than one cycle");
  a_fetch_is_read: assert property (mem_req && mem_fetch |-> !mem_we)
    else $error("target fetch marked as write");
  a_ack_needs_line: assert property (
    $rose(inta_req) |-> maskable_request_line)
    else $error("acknowledge cycle without maskable request");
  a_ack_req_holds: assert property (inta_req && !inta_ack |=> inta_req)
    else $error("acknowledge request dropped early");
  a_mem_req_holds: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request changed before ack");
endmodule
bind bpc_core bpc_core_chk u_chk (.*);
`default_nettype wire

// ===== sim/bpc_mem_model.sv
// System memory and acknowledge responder facing the core's memory port.
// Assumes word accesses; answers alternately at once and after two waits.
`timescale 1ns/10ps
`default_nettype none
module bpc_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_fetch,
  input wire logic [19:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  input wire logic inta_req,
  output logic inta_ack,
  output logic [7:0] inta_type,
  output logic [19:0] last_rd,
  output logic [19:0] last_fetch,
  output int rd_count
);
  logic [15:0] mem [512];
  logic [1:0] dly;
  logic slow;
  assign inta_type = 8'h21;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h5a5a;
      dly <= 2'h0;
      slow <= 1'b0;
      inta_ack <= 1'b0;
      last_rd <= '0;
      last_fetch <= '0;
      rd_count <= 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      inta_ack <= inta_req && !inta_ack;
      if (mem_req && !mem_ack) begin
        if (dly == {slow, 1'b0}) begin
          mem_ack <= 1'b1;
          dly <= 2'h0;
          slow <= ~slow;
          if (mem_we) begin
            mem[mem_addr[9:1]] <= mem_wdata;
          end else begin
            mem_rdata <= mem[mem_addr[9:1]];
            if (mem_fetch) begin
              last_fetch <= mem_addr;
            end else begin
              last_rd <= mem_addr;
              rd_count <= rd_count + 1;
            end
          end
        end else begin
          dly <= dly + 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the branch and processor control core.
// Assumes bpc_mem_model as memory and an APB master built here.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import bpc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic nmi_n = 1, maskable_request_line = 0, test_n = 1, err;
  logic pready, pslverr, mem_req, mem_we, mem_fetch, mem_ack, inta_req;
  logic inta_ack, lock_out, queue_flush, inta_seen = 0, lock_seen = 0;
  logic [19:0] mem_addr, last_rd, last_fetch;
  logic [15:0] mem_wdata, mem_rdata;
  logic [7:0] inta_type;
  logic [5:0] esc_opcode;
  int rd_count, n, errors = 0, cmp_count = 0;
  bpc_core DUT (.*);
  bpc_mem_model MEM (.*);
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (inta_req === 1'b1) inta_seen <= 1'b1;
    if (lock_out === 1'b1) lock_seen <= 1'b1;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chkr(input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(q[15:0], e)
  endtask
  task automatic idle();
    do apb(1'b0, OFS_STATUS, 32'h0); while (q[5] !== 1'b0);
  endtask
  task automatic run(input logic [31:0] cmd, input logic [31:0] opnd);
    apb(1'b1, OFS_OPND, opnd);
    apb(1'b1, OFS_CMD, cmd);
    idle();
  endtask
  task automatic setr(input logic [15:0] ip, cs, sp, fl);
    apb(1'b1, OFS_IP, {16'h0, ip});
    apb(1'b1, OFS_CS, {16'h0, cs});
    apb(1'b1, OFS_SP, {16'h0, sp});
    apb(1'b1, OFS_SS, 32'h0);
    apb(1'b1, OFS_FLAGS, {16'h0, fl});
  endtask
  function automatic logic cc_exp(input logic [3:0] cc, input logic [15:0] f);
    logic c, z, s, o, p;
    logic [7:0] b;
    {o, s, z, p, c} = {f[11], f[7], f[6], f[2], f[0]};
    b = {(s ^ o) | z, s ^ o, p, s, c | z, z, c, o};
    return b[cc[3:1]] ^ cc[0];
  endfunction
  task automatic t_far();
    MEM.mem[9'h073] = 16'hbeef;
    setr(16'h0, 16'h0, 16'h0100, 16'h0002);
    run(32'(OP_JMP_FAR), 32'h0009_0456);
    chkr(OFS_IP, 16'h0456);
    chkr(OFS_CS, 16'h0009);
    `CHK(last_fetch, 20'h004e6)
    chkr(OFS_FETCH, 16'hbeef);
    MEM.mem[9'h0b0] = 16'h1234;
    MEM.mem[9'h0b1] = 16'h0007;
    apb(1'b1, OFS_EA, 32'h160);
    run(32'(OP_JMP_FAR_IND), 32'h0);
    chkr(OFS_IP, 16'h1234);
    chkr(OFS_CS, 16'h0007);
    `CHK(last_fetch, 20'h012a4)
    apb(1'b0, 8'h40, 32'h0);
    `CHK(err, 1'b1)
  endtask
  task automatic t_jcc();
    logic [15:0] pat [3] = '{16'h0002, 16'h00c7, 16'h0802};
    logic [7:0] d;
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 16; c++) begin
        d = (c % 3 == 0) ? 8'h80 : (c % 3 == 1) ? 8'h7f : 8'h00;
        setr(16'h1000, 16'h0, 16'h0100, pat[p]);
        run({20'h0, 4'(c), 3'h0, OP_JCC}, {24'h0, d});
        chkr(OFS_IP, cc_exp(4'(c), pat[p]) ? 16'h1000 + {{8{d[7]}}, d} : 16'h1000);
      end
    end
  endtask
  task automatic t_loop();
    bpc_op_t lop [8] = '{OP_LOOP, OP_LOOP, OP_LOOPZ, OP_LOOPZ, OP_LOOPNZ,
      OP_LOOPNZ, OP_BRANCH_IF_COUNT_ZERO, OP_BRANCH_IF_COUNT_ZERO};
    logic [15:0] lcx [8] = '{16'h1, 16'h0, 16'h2, 16'h2, 16'h2, 16'h2, 16'h0, 16'h5};
    logic [7:0] lz = 8'b0010_0100;
    logic [7:0] lt = 8'b0101_0110;
    for (int i = 0; i < 8; i++) begin
      setr(16'h0200, 16'h0, 16'h0100, lz[i] ? 16'h0042 : 16'h0002);
      apb(1'b1, OFS_CX, {16'h0, lcx[i]});
      run(32'(lop[i]), 32'h0000_00f0);
      chkr(OFS_IP, lt[i] ? 16'h01f0 : 16'h0200);
      chkr(OFS_CX, lop[i] == OP_BRANCH_IF_COUNT_ZERO ? lcx[i] : lcx[i] - 16'h1);
    end
  endtask
  task automatic t_int();
    logic [15:0] fl;
    logic [8:0] vi;
    for (int k = 0; k < 4; k++) begin
      fl = (k == 2) ? 16'h0b03 : 16'h0303;
      vi = (k == 0) ? 9'h040 : (k == 1) ? 9'h006 : 9'h008;
      MEM.mem[vi] = 16'h0300 + 16'(k);
      MEM.mem[vi + 9'h1] = 16'h0000;
      setr(16'h0020, 16'h0010, 16'h0100, fl);
      run(32'(k == 0 ? OP_INT : k == 1 ? OP_INT3 : OP_INTO), 32'h20);
      if (k == 3) begin
        chkr(OFS_IP, 16'h0020);
        chkr(OFS_SP, 16'h0100);
      end else begin
        chkr(OFS_IP, 16'h0300 + 16'(k));
        chkr(OFS_CS, 16'h0000);
        chkr(OFS_SP, 16'h00fa);
        chkr(OFS_FLAGS, fl & ~16'h0300);
        `CHK({MEM.mem[9'h7f], MEM.mem[9'h7e], MEM.mem[9'h7d]}, {fl, 32'h0010_0020})
        run(32'(OP_TRAP_RETURN), 32'h0);
        chkr(OFS_IP, 16'h0020);
        chkr(OFS_CS, 16'h0010);
        chkr(OFS_SP, 16'h0100);
        chkr(OFS_FLAGS, fl);
      end
    end
    `CHK(inta_seen, 1'b0)
  endtask
  task automatic t_flag();
    bpc_op_t fop [5] = '{OP_CLC, OP_STC, OP_CMC, OP_CLD, OP_STD};
    logic [15:0] s, m [5] = '{16'h1, 16'h1, 16'h1, 16'h400, 16'h400};
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 5; i++) begin
        s = j ? 16'h0402 : 16'h08c7;
        setr(16'h0, 16'h0, 16'h0100, s);
        run(32'(fop[i]), 32'h0);
        chkr(OFS_FLAGS, i == 2 ? s ^ m[i] : i % 3 == 1 ? s | m[i] : s & ~m[i]);
      end
    end
  endtask
  task automatic t_halt();
    {MEM.mem[9'h4], MEM.mem[9'h5]} = {16'h0222, 16'h0};
    {MEM.mem[9'h42], MEM.mem[9'h43]} = {16'h0333, 16'h0};
    setr(16'h0040, 16'h0, 16'h0100, 16'h0002);
    @(posedge pclk) maskable_request_line <= 1'b1;
    apb(1'b1, OFS_CMD, 32'(OP_HLT));
    repeat (20) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(q[3], 1'b1)
    chkr(OFS_IP, 16'h0040);
    `CHK(inta_seen, 1'b0)
    @(posedge pclk) nmi_n <= 1'b0;
    repeat (8) @(posedge pclk);
    nmi_n <= 1'b1;
    repeat (20) @(posedge pclk);
    idle();
    `CHK(q[3], 1'b0)
    chkr(OFS_IP, 16'h0222);
    apb(1'b1, OFS_FLAGS, 32'h0202);
    repeat (20) @(posedge pclk);
    idle();
    chkr(OFS_IP, 16'h0333);
    `CHK(inta_seen, 1'b1)
    @(posedge pclk) maskable_request_line <= 1'b0;
  endtask
  task automatic t_sync();
    setr(16'h0050, 16'h0, 16'h0100, 16'h08c7);
    apb(1'b1, OFS_CMD, 32'(OP_WAIT));
    repeat (20) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(q[4], 1'b1)
    @(posedge pclk) test_n <= 1'b0;
    repeat (10) @(posedge pclk);
    idle();
    `CHK(q[4], 1'b0)
    chkr(OFS_FLAGS, 16'h08c7);
    @(posedge pclk) test_n <= 1'b1;
    apb(1'b1, OFS_EA, 32'h150);
    n = rd_count;
    run({10'h0, 6'h2d, 3'h0, 1'b1, 7'h0, OP_ESC}, 32'h0);
    `CHK({esc_opcode, last_rd}, {6'h2d, 20'h00150})
    `CHK(rd_count, n + 1)
    run({10'h0, 6'h13, 11'h0, OP_ESC}, 32'h0);
    `CHK(esc_opcode, 6'h13)
    `CHK(rd_count, n + 1)
    for (int m = 1; m >= 0; m--) begin
      apb(1'b1, OFS_CFG, 32'(m));
      setr(16'h0, 16'h0, 16'h0100, 16'h0002);
      run(32'(OP_LOCK), 32'h0);
      chkr(OFS_FLAGS, 16'h0002);
      lock_seen = 1'b0;
      run(32'(OP_STC), 32'h0);
      `CHK(lock_seen, 1'(m))
      `CHK(lock_out, 1'b0)
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_far();
    t_jcc();
    t_loop();
    t_int();
    t_flag();
    t_halt();
    t_sync();
    summarize();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    errors++;
    $display("BAD %0t timeout", $time);
    summarize();
  end
endmodule
`default_nettype wire
